// file: tvams_pkg.sv
// Constants and types shared by the TV audio mode select and status block.
// Assumes a single 40 MHz system clock and register access over the two-wire pins.
package tvams_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SUB_CFG = 8'h00;
  localparam logic [7:0] SUB_CTL = 8'h06;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // Field positions, configuration byte
  localparam int CFG_STOP_SEL_BIT = 6;

  // Field positions, control byte
  localparam int CTL_MUTE_OFF_BIT = 0;
  localparam int CTL_FORCE_MONO_BIT = 1;
  localparam int CTL_SAP_SEL_BIT = 2;
  localparam int CTL_MONO_LEFT_SECOND_AUDIO_RIGHT_BIT = 3;
  localparam int CTL_NORM_SEL2_BIT = 4;
  localparam int CTL_NORM_SEL1_BIT = 5;

  // Field positions, status byte
  localparam int ST_POR_BIT = 7;
  localparam int ST_PILOT_BIT = 6;
  localparam int ST_SAP_CAR_BIT = 5;
  localparam int ST_NOISE_BIT = 4;
  localparam int ST_STEREO_RX_BIT = 3;
  localparam int ST_SAP_RX_BIT = 2;
  localparam logic [1:0] ST_LOW_BITS = 2'h3;

  // Device address on the two-wire bus; value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h5a;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_MUTE    = 3'b000,
    SRC_MONO    = 3'b001,
    SRC_LEFT    = 3'b010,
    SRC_RIGHT   = 3'b011,
    SRC_SAP     = 3'b100,
    SRC_EXT_SAP = 3'b101
  } tvams_src_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_ADDR     = 4'b0001,
    ST_ACK_ADDR = 4'b0010,
    ST_SUB      = 4'b0011,
    ST_ACK_SUB  = 4'b0100,
    ST_WDATA    = 4'b0101,
    ST_ACK_WR   = 4'b0110,
    ST_RDATA    = 4'b0111,
    ST_RACK     = 4'b1000
  } tvams_i2c_state_t;

endpackage

// file: tvams_reg_if.sv
// Register access carrier between the two-wire slave and the register file.
// Assumes both ends run on the system clock.
interface tvams_reg_if;
  logic wr_stb;
  logic [7:0] wr_sub;
  logic [7:0] wr_data;
  logic rd_stb;
  logic [7:0] rd_data;

  modport slave (output wr_stb, output wr_sub, output wr_data, output rd_stb, input rd_data);
  modport regs (input wr_stb, input wr_sub, input wr_data, input rd_stb, output rd_data);
endinterface

// file: tvams_i2c_slave.sv
// Two-wire bus slave: subaddress writes with auto increment, status byte reads.
// Assumes SCL and SDA arrive synchronous to the system clock.
module tvams_i2c_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  tvams_reg_if.slave bus
);

  tvams_pkg::tvams_i2c_state_t state_q;
  logic scl_q;
  logic sda_q;
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic got_q;
  logic rw_q;
  logic [7:0] sub_q;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  // ----------------------------------------------------------------
  // Line events
  // ----------------------------------------------------------------
  // Previous samples give edges and start/stop conditions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_c = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_c = scl_in & scl_q & ~sda_q & sda_in;

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  // SDA only changes on SCL falls so start/stop are never faked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= tvams_pkg::ST_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 3'h0;
      got_q <= 1'b0;
      rw_q <= 1'b0;
      sub_q <= 8'h00;
      sda_oe <= 1'b0;
      bus.wr_stb <= 1'b0;
      bus.wr_sub <= 8'h00;
      bus.wr_data <= 8'h00;
      bus.rd_stb <= 1'b0;
    end else begin
      bus.wr_stb <= 1'b0;
      bus.rd_stb <= 1'b0;
      if (start_c) begin
        state_q <= tvams_pkg::ST_ADDR;
        cnt_q <= 3'h0;
        got_q <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        state_q <= tvams_pkg::ST_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          tvams_pkg::ST_ADDR, tvams_pkg::ST_SUB, tvams_pkg::ST_WDATA: begin
            sh_q <= {sh_q[6:0], sda_in};
            cnt_q <= cnt_q + 3'h1;
            got_q <= (cnt_q == 3'h7);
          end
          tvams_pkg::ST_RDATA: begin
            cnt_q <= cnt_q + 3'h1;
            got_q <= (cnt_q == 3'h7);
          end
          tvams_pkg::ST_RACK: begin
            // A not-acknowledge ends the read; wait for stop
            if (sda_in) begin
              state_q <= tvams_pkg::ST_IDLE;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_q)
          tvams_pkg::ST_ADDR: begin
            if (got_q) begin
              got_q <= 1'b0;
              if (sh_q[7:1] == tvams_pkg::DEV_ADDR) begin
                rw_q <= sh_q[0];
                sda_oe <= 1'b1;
                state_q <= tvams_pkg::ST_ACK_ADDR;
              end else begin
                state_q <= tvams_pkg::ST_IDLE;
              end
            end
          end
          tvams_pkg::ST_ACK_ADDR, tvams_pkg::ST_RACK: begin
            if (rw_q) begin
              sh_q <= bus.rd_data;
              sda_oe <= ~bus.rd_data[7];
              bus.rd_stb <= 1'b1;
              cnt_q <= 3'h0;
              state_q <= tvams_pkg::ST_RDATA;
            end else begin
              sda_oe <= 1'b0;
              state_q <= tvams_pkg::ST_SUB;
            end
          end
          tvams_pkg::ST_SUB: begin
            if (got_q) begin
              got_q <= 1'b0;
              sub_q <= sh_q;
              sda_oe <= 1'b1;
              state_q <= tvams_pkg::ST_ACK_SUB;
            end
          end
          tvams_pkg::ST_ACK_SUB, tvams_pkg::ST_ACK_WR: begin
            sda_oe <= 1'b0;
            state_q <= tvams_pkg::ST_WDATA;
          end
          tvams_pkg::ST_WDATA: begin
            if (got_q) begin
              got_q <= 1'b0;
              sda_oe <= 1'b1;
              bus.wr_stb <= 1'b1;
              bus.wr_sub <= sub_q;
              bus.wr_data <= sh_q;
              sub_q <= sub_q + 8'h01;
              state_q <= tvams_pkg::ST_ACK_WR;
            end
          end
          tvams_pkg::ST_RDATA: begin
            if (got_q) begin
              got_q <= 1'b0;
              sda_oe <= 1'b0;
              state_q <= tvams_pkg::ST_RACK;
            end else begin
              sda_oe <= ~sh_q[6];
              sh_q <= {sh_q[6:0], 1'b0};
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule

// file: tvams_top.sv
// Audio mode decision and status logic of a multichannel TV sound decoder.
// Assumes detector flags and bus pins are synchronous to CLK_SYS.
module tvams_top (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Two-wire register bus
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Detector flags
  input wire logic PILOT_DET,
  input wire logic SAP_CARRIER_DET,
  input wire logic NOISE_DET,
  // Audio source selects
  output tvams_pkg::tvams_src_t LEFT_OUTPUT_SEL,
  output tvams_pkg::tvams_src_t RIGHT_OUTPUT_SEL,
  output tvams_pkg::tvams_src_t NORMAL_OUTPUT_SEL,
  // Demodulator suspend
  output logic SAP_DEMOD_HOLD,
  output logic STEREO_DEMOD_HOLD,
  // Status byte
  output logic [7:0] RECEIVER_STATUS
);

  tvams_reg_if rif ();

  logic [7:0] cfg_q;
  logic [7:0] ctl_q;
  logic por_q;
  logic sda_oe_w;
  logic mute_c;
  logic sap_ok_c;
  logic st_ok_c;
  logic stereo_rx_c;
  logic sap_rx_c;
  logic [7:0] status_c;
  tvams_pkg::tvams_src_t left_c;
  tvams_pkg::tvams_src_t right_c;
  tvams_pkg::tvams_src_t norm_c;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Forced mono overrides both the stereo matrix and the normal output
  function automatic logic mono_forced(input logic [7:0] ctl);
    return ctl[tvams_pkg::CTL_FORCE_MONO_BIT];
  endfunction

  // Second audio chosen and its carrier present; both selectors ask this
  function automatic logic sap_wanted(input logic [7:0] ctl, input logic carrier);
    return ctl[tvams_pkg::CTL_SAP_SEL_BIT] & carrier;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  tvams_i2c_slave u_slave (
    .clk(CLK_SYS),
    .rst(RST),
    .scl_in(SCL_IN),
    .sda_in(SDA_IN),
    .sda_oe(sda_oe_w),
    .bus(rif.slave)
  );

  // ----------------------------------------------------------------
  // Write registers
  // ----------------------------------------------------------------
  // Other subaddresses hold analog trims and are accepted but dropped
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cfg_q <= tvams_pkg::CFG_RESET;
      ctl_q <= tvams_pkg::CTL_RESET;
    end else if (rif.wr_stb) begin
      if (rif.wr_sub == tvams_pkg::SUB_CFG) begin
        cfg_q <= rif.wr_data;
      end else if (rif.wr_sub == tvams_pkg::SUB_CTL) begin
        ctl_q <= rif.wr_data;
      end
    end
  end

  // Power-on flag; cleared once the status byte has been fetched
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      por_q <= 1'b1;
    end else if (rif.rd_stb) begin
      por_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Mode decision
  // ----------------------------------------------------------------
  // Noise gates what the second audio demodulator may deliver, and stereo only with the stop select set
  assign mute_c = ~ctl_q[tvams_pkg::CTL_MUTE_OFF_BIT];
  assign sap_ok_c = SAP_CARRIER_DET & ~NOISE_DET;
  assign st_ok_c = PILOT_DET & ~(NOISE_DET & cfg_q[tvams_pkg::CFG_STOP_SEL_BIT]);

  // Left and right selection, purely from current bits and flags
  always_comb begin
    left_c = tvams_pkg::SRC_MONO;
    right_c = tvams_pkg::SRC_MONO;
    stereo_rx_c = 1'b0;
    sap_rx_c = 1'b0;
    if (mute_c) begin
      left_c = tvams_pkg::SRC_MUTE;
      right_c = tvams_pkg::SRC_MUTE;
    end else if (mono_forced(ctl_q)) begin
      left_c = tvams_pkg::SRC_MONO;
      right_c = tvams_pkg::SRC_MONO;
    end else if (sap_wanted(ctl_q, sap_ok_c)) begin
      sap_rx_c = 1'b1;
      right_c = tvams_pkg::SRC_SAP;
      left_c = ctl_q[tvams_pkg::CTL_MONO_LEFT_SECOND_AUDIO_RIGHT_BIT] ? tvams_pkg::SRC_MONO : tvams_pkg::SRC_SAP;
    end else if (st_ok_c && !sap_wanted(ctl_q, SAP_CARRIER_DET)) begin
      // Stereo-only broadcast plays stereo even with second audio chosen
      stereo_rx_c = 1'b1;
      left_c = tvams_pkg::SRC_LEFT;
      right_c = tvams_pkg::SRC_RIGHT;
    end
  end

  // Normal output selection
  always_comb begin
    if (mute_c) begin
      norm_c = tvams_pkg::SRC_MUTE;
    end else if (NOISE_DET) begin
      norm_c = tvams_pkg::SRC_MONO;
    end else if (ctl_q[tvams_pkg::CTL_NORM_SEL2_BIT] || mono_forced(ctl_q)) begin
      norm_c = tvams_pkg::SRC_MONO;
    end else if (ctl_q[tvams_pkg::CTL_NORM_SEL1_BIT]) begin
      norm_c = tvams_pkg::SRC_EXT_SAP;
    end else if (sap_wanted(ctl_q, SAP_CARRIER_DET)) begin
      norm_c = tvams_pkg::SRC_SAP;
    end else begin
      norm_c = tvams_pkg::SRC_MONO;
    end
  end

  // Status byte as seen by the host
  always_comb begin
    status_c = 8'h00;
    status_c[tvams_pkg::ST_POR_BIT] = por_q;
    status_c[tvams_pkg::ST_PILOT_BIT] = st_ok_c;
    status_c[tvams_pkg::ST_SAP_CAR_BIT] = sap_ok_c;
    status_c[tvams_pkg::ST_NOISE_BIT] = NOISE_DET;
    status_c[tvams_pkg::ST_STEREO_RX_BIT] = stereo_rx_c;
    status_c[tvams_pkg::ST_SAP_RX_BIT] = sap_rx_c;
    status_c[1:0] = tvams_pkg::ST_LOW_BITS;
  end

  // Bus reads the live byte, so a fetch never sees a stale flag
  assign rif.rd_data = status_c;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Source selects; registered for clean pins, one cycle behind the inputs
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      LEFT_OUTPUT_SEL <= tvams_pkg::SRC_MUTE;
      RIGHT_OUTPUT_SEL <= tvams_pkg::SRC_MUTE;
      NORMAL_OUTPUT_SEL <= tvams_pkg::SRC_MUTE;
    end else begin
      LEFT_OUTPUT_SEL <= left_c;
      RIGHT_OUTPUT_SEL <= right_c;
      NORMAL_OUTPUT_SEL <= norm_c;
    end
  end

  // Second audio suspend follows the noise flag; stereo suspend follows noise gated by the stop select
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      SAP_DEMOD_HOLD <= 1'b0;
      STEREO_DEMOD_HOLD <= 1'b0;
    end else begin
      SAP_DEMOD_HOLD <= NOISE_DET;
      STEREO_DEMOD_HOLD <= NOISE_DET & cfg_q[tvams_pkg::CFG_STOP_SEL_BIT];
    end
  end

  // Status copy on the pins; same cycle as the selects it describes
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RECEIVER_STATUS <= 8'h00;
    end else begin
      RECEIVER_STATUS <= status_c;
    end
  end

  // Open-drain data pin: level stays low, only the enable moves
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
    end else begin
      SDA_OUT <= 1'b0;
      SDA_OE <= sda_oe_w;
    end
  end

endmodule

// file: tvams_top_props.sv
// Port assertions for the TV audio mode decision block.
// Assumes one clock domain; bound to every tvams_top below.
module tvams_top_props (
  // Clock and reset
  input logic CLK_SYS,
  input logic RST,
  // Detector flags
  input logic PILOT_DET,
  input logic SAP_CARRIER_DET,
  input logic NOISE_DET,
  // Results
  input tvams_pkg::tvams_src_t LEFT_OUTPUT_SEL,
  input tvams_pkg::tvams_src_t RIGHT_OUTPUT_SEL,
  input tvams_pkg::tvams_src_t NORMAL_OUTPUT_SEL,
  input logic [7:0] RECEIVER_STATUS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  // ------------------------------------------
  // Results follow inputs one cycle later
  // ------------------------------------------
  // First edge after reset still shows reset values, hence the guard
  AST_NOISE_BIT:
    assert property (!$past(RST) |-> RECEIVER_STATUS[4] == $past(NOISE_DET))
    else $error("noise status bit wrong");
  AST_PILOT_BIT:
    assert property (!$past(RST) && !$past(NOISE_DET) |-> RECEIVER_STATUS[6] == $past(PILOT_DET))
    else $error("pilot status bit wrong");
  AST_SAP_CAR_BIT:
    assert property (!$past(RST) |-> RECEIVER_STATUS[5] == ($past(SAP_CARRIER_DET) && !$past(NOISE_DET)))
    else $error("carrier status bit wrong");
  AST_NOISE_NO_SAP:
    assert property (!$past(RST) && $past(NOISE_DET) |-> !RECEIVER_STATUS[2]
      && LEFT_OUTPUT_SEL != tvams_pkg::SRC_SAP && RIGHT_OUTPUT_SEL != tvams_pkg::SRC_SAP)
    else $error("second audio out under noise");
  AST_WEAK_NORMAL:
    assert property (!$past(RST) && $past(NOISE_DET) |-> NORMAL_OUTPUT_SEL inside
      {tvams_pkg::SRC_MONO, tvams_pkg::SRC_MUTE})
    else $error("normal output not mono on weak field");
  AST_MUTE_ALL:
    assert property (LEFT_OUTPUT_SEL == tvams_pkg::SRC_MUTE |-> RIGHT_OUTPUT_SEL ==
      tvams_pkg::SRC_MUTE && NORMAL_OUTPUT_SEL == tvams_pkg::SRC_MUTE)
    else $error("partial mute");
  AST_STEREO_RX:
    assert property (RECEIVER_STATUS[3] |-> LEFT_OUTPUT_SEL == tvams_pkg::SRC_LEFT
      && RIGHT_OUTPUT_SEL == tvams_pkg::SRC_RIGHT)
    else $error("stereo reception without stereo out");
  AST_SAP_RX:
    assert property (RECEIVER_STATUS[2] |-> RIGHT_OUTPUT_SEL == tvams_pkg::SRC_SAP)
    else $error("second audio reception without its output");
  AST_POR_FLAG:
    assert property ($past(RST) |-> ##1 RECEIVER_STATUS[7])
    else $error("power-on flag missing");
  // Main scenarios reached
  cover property (RECEIVER_STATUS[3]);
  cover property (RECEIVER_STATUS[2]);
  cover property (NORMAL_OUTPUT_SEL == tvams_pkg::SRC_EXT_SAP);
endmodule

bind tvams_top tvams_top_props u_props (.CLK_SYS, .RST, .PILOT_DET, .SAP_CARRIER_DET,
  .NOISE_DET, .LEFT_OUTPUT_SEL, .RIGHT_OUTPUT_SEL, .NORMAL_OUTPUT_SEL, .RECEIVER_STATUS);

// file: tvams_host.sv
// Two-wire bus master standing in for the host controller.
// Assumes the bench resolves the open-drain data line with a pull-up.
module tvams_host (
  // Clock and line
  input logic clk,
  input logic sda_line,
  // Driven pins
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Step off the edge so the device never sees a race
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // One bit; data moves only two cycles into the low phase
  task automatic put_bit(input logic b, output logic seen);
    tick(2);
    sda_drv = b;
    tick(2);
    scl = 1'b1;
    tick(2);
    seen = sda_line;
    tick(2);
    scl = 1'b0;
  endtask
  // Byte out, then release for the acknowledge
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask
  // Only called once the bench has settled reset and supply
  task automatic start();
    tick(4);
    sda_drv = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_drv = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_drv = 1'b1;
    tick(4);
  endtask
  // Single register write; ok is set when all three bytes were acknowledged
  task automatic wr(input logic [7:0] sub, input logic [7:0] val, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    start();
    put_byte({tvams_pkg::DEV_ADDR, 1'b0}, a0);
    put_byte(sub, a1);
    put_byte(val, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  // One status byte, closed with a not-acknowledge
  task automatic rd(output logic [7:0] d, output logic ok);
    logic s;
    start();
    put_byte({tvams_pkg::DEV_ADDR, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(1'b1, s);
    stop();
  endtask
endmodule

// file: tv_audio_mode_select_status_bench.sv
// Self-checking bench for the TV audio mode decision block.
// Assumes tvams_top, its package and the host model are compiled first.
module tv_audio_mode_select_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pilot = 1'b0;
  logic sapc = 1'b0;
  logic noise = 1'b0;
  wire scl;
  wire sda_m;
  wire sda_out;
  wire sda_oe;
  wire shold;
  wire sthold;
  wire [7:0] status;
  wire sda_line = sda_m & ~sda_oe;
  tvams_pkg::tvams_src_t lsel;
  tvams_pkg::tvams_src_t rsel;
  tvams_pkg::tvams_src_t nsel;
  int n_mismatch = 0;
  int num_checks = 0;
  // 40 MHz system clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  tvams_top DUT (.CLK_SYS(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .PILOT_DET(pilot), .SAP_CARRIER_DET(sapc), .NOISE_DET(noise),
    .LEFT_OUTPUT_SEL(lsel), .RIGHT_OUTPUT_SEL(rsel), .NORMAL_OUTPUT_SEL(nsel),
    .SAP_DEMOD_HOLD(shold), .STEREO_DEMOD_HOLD(sthold), .RECEIVER_STATUS(status));
  tvams_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_m));
  // ------------------------------------------
  // Shared checking
  // ------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Program both registers, set detectors, compare; det is {stop, pilot, carrier, noise},
  // exp holds left, right, normal source codes one per nibble
  task automatic mode(input logic [7:0] ctl, input logic [3:0] det, input logic [11:0] exp,
      input logic [1:0] rx);
    logic ok;
    logic ns;
    host.wr(tvams_pkg::SUB_CFG, {1'b0, det[3], 6'h00}, ok);
    chk("cfg ack", 8'h01, {7'h0, ok});
    host.wr(tvams_pkg::SUB_CTL, ctl, ok);
    chk("ctl ack", 8'h01, {7'h0, ok});
    {pilot, sapc, noise} = det[2:0];
    ns = det[0] & det[3];
    repeat (3) @(posedge clk);
    #2;
    chk("left", {4'h0, exp[11:8]}, {5'h0, lsel});
    chk("right", {4'h0, exp[7:4]}, {5'h0, rsel});
    chk("normal", {4'h0, exp[3:0]}, {5'h0, nsel});
    chk("reception", {6'h0, rx}, {6'h0, status[3:2]});
    chk("flags", {3'h0, det[0], ns, det[2] & ~ns, det[1] & ~det[0], det[0]},
      {3'h0, shold, sthold, status[6:4]});
  endtask
  // Muted start, power-on flag on first read only
  task automatic t_reset();
    logic [7:0] d;
    logic ok;
    chk("start muted", 8'h00, {5'h0, lsel});
    host.rd(d, ok);
    chk("first read", 8'h83, d);
    host.rd(d, ok);
    chk("second read", 8'h03, d);
    chk("read ack", 8'h01, {7'h0, ok});
    chk("sda level", 8'h00, {7'h0, sda_out});
  endtask
  task automatic t_lr();
    mode(8'h01, 4'h0, 12'h111, 2'h0);
    mode(8'h01, 4'h4, 12'h231, 2'h2);
    mode(8'h03, 4'h4, 12'h111, 2'h0);
  endtask
  task automatic t_sap();
    mode(8'h05, 4'h2, 12'h444, 2'h1);
    mode(8'h0d, 4'h2, 12'h144, 2'h1);
    mode(8'h05, 4'h6, 12'h444, 2'h1);
    mode(8'h01, 4'h6, 12'h231, 2'h2);
    mode(8'h07, 4'h6, 12'h111, 2'h0);
  endtask
  task automatic t_normal();
    mode(8'h25, 4'h2, 12'h445, 2'h1);
    mode(8'h35, 4'h2, 12'h441, 2'h1);
    mode(8'h15, 4'h6, 12'h441, 2'h1);
  endtask
  // Weak field: second audio gone, stop select decides stereo
  task automatic t_noise();
    mode(8'h01, 4'h7, 12'h231, 2'h2);
    mode(8'h05, 4'h7, 12'h111, 2'h0);
    mode(8'h01, 4'hf, 12'h111, 2'h0);
    mode(8'h2d, 4'h3, 12'h111, 2'h0);
  endtask
  // Mute again after running: every output drops
  task automatic t_mute();
    mode(8'h00, 4'h0, 12'h000, 2'h0);
  endtask
  // Main sequence; bus traffic only after reset has settled
  initial begin
    repeat (16) @(posedge clk);
    #2;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    t_reset();
    t_lr();
    t_sap();
    t_normal();
    t_noise();
    t_mute();
    final_report();
  end
  // Watchdog: the run needs about eight thousand cycles, a fifth of this limit
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
endmodule
